// ==== hdl/spi_buf_pkg.sv ====
// Constants and carrier types for the SPI status and data buffer
package spi_buf_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int unsigned ADDR_W      = 10;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned BE_W        = 4;
   localparam int unsigned IDX_W       = 8;
   localparam int unsigned IDX_LSB     = 2;

   ////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [7:0]  IDX_CTRL_ONE    = 8'hE8;
   localparam logic [7:0]  IDX_CTRL_TWO    = 8'hE9;
   localparam logic [7:0]  IDX_FLAG_STATUS = 8'hEB;
   localparam logic [7:0]  IDX_DATA_HIGH   = 8'hEC;
   localparam logic [7:0]  IDX_DATA_LOW    = 8'hED;
   localparam logic [7:0]  IDX_DATA_WORD   = 8'hEE;

   ////////////////////////////////////////////////////////////////////////
   // Reset values and writable-bit masks
   localparam logic [7:0]  DATA_RESET      = 8'h00;
   localparam logic [7:0]  CTRL_ONE_RESET  = 8'h00;
   localparam logic [7:0]  CTRL_TWO_RESET  = 8'h00;
   localparam logic [7:0]  CTRL_ONE_MASK   = 8'h88;
   localparam logic [7:0]  CTRL_TWO_MASK   = 8'h11;
   localparam logic        TX_EMPTY_RESET  = 1'b1;
   localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // Field layouts
   typedef struct packed {
      logic       rx_full_flag;
      logic       rsvd6;
      logic       tx_empty_flag;
      logic       mode_fault_flag;
      logic [3:0] rsvd3_0;
   } flag_status_t;

   typedef struct packed {
      logic       irq_enable;
      logic [2:0] rsvd6_4;
      logic       controller_select;
      logic [2:0] rsvd2_0;
   } ctrl_one_t;

   typedef struct packed {
      logic [2:0] rsvd7_5;
      logic       fault_detect_enable;
      logic [2:0] rsvd3_1;
      logic       transfer_width_select;
   } ctrl_two_t;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } data_word_t;

   typedef struct packed {
      logic              read;
      logic              write;
      logic [ADDR_W-1:0] address;
      logic [BE_W-1:0]   byteenable;
      logic [DATA_W-1:0] writedata;
   } avl_req_t;

endpackage : spi_buf_pkg

// ==== hdl/rx_data_hold.sv ====
// Receive data register with one held word behind it
`timescale 1ns/100ps
`default_nettype none
module rx_data_hold (
   input  wire logic                    clock_i,
   input  wire logic                    rst_b_i,
   input  wire logic                    rx_done_i,
   input  wire spi_buf_pkg::data_word_t rx_word_i,
   input  wire logic                    xfer_start_i,
   input  wire logic                    service_i,
   output var  spi_buf_pkg::data_word_t rx_data_o,
   output var  logic                    rx_full_o
);
   import spi_buf_pkg::*;

   data_word_t data_r;
   data_word_t data_nxt;
   data_word_t held_r;
   data_word_t held_nxt;
   logic       full_r;
   logic       full_nxt;
   logic       held_vld_r;
   logic       held_vld_nxt;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      data_nxt     = data_r;
      held_nxt     = held_r;
      full_nxt     = full_r;
      held_vld_nxt = held_vld_r;
      if (service_i) begin
         if (held_vld_r) begin
            data_nxt     = held_r;
            held_vld_nxt = 1'b0;
         end else begin
            full_nxt = 1'b0;
         end
      end
      if (xfer_start_i && held_vld_r && !service_i) begin
         held_vld_nxt = 1'b0;
      end
      if (rx_done_i) begin
         if (!full_nxt) begin
            data_nxt = rx_word_i;
            full_nxt = 1'b1;
         end else begin
            held_nxt     = rx_word_i;
            held_vld_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         data_r     <= {DATA_RESET, DATA_RESET};
         held_r     <= {DATA_RESET, DATA_RESET};
         full_r     <= 1'b0;
         held_vld_r <= 1'b0;
      end else begin
         data_r     <= data_nxt;
         held_r     <= held_nxt;
         full_r     <= full_nxt;
         held_vld_r <= held_vld_nxt;
      end
   end

   assign rx_data_o = data_r;
   assign rx_full_o = full_r;

endmodule : rx_data_hold
`default_nettype wire

// ==== hdl/spi_status_and_data_buffer.sv ====
// SPI status flags, split data register and Avalon-MM register slave
//
// Summary of operation
// - Status register readable anytime; writes to it change nothing.
// - Bit 7 sets once a received word lands in the data register.
// - Bit 5 is one while the transmit register can take a word.
// - Bit 4 sets while slave select is low as master with detection on.
// - Status read seeing bit 4, then control one write, clears the fault.
// - Status read seeing bit 7, then low or word read, clears it.
// - High byte reads never touch the receive flag.
// - Status read seeing bit 5, then low write, clears it; high writes don't.
// - Data writes while transmit-empty is zero are dropped.
// - Low-only write leaves the high byte as last written, in either width.
// - Data word splits high 15..8, low 7..0; both reset zero.
// - Queued word goes to the shifter as soon as it is idle.
// - Reception with flag clear copies the word in and sets the flag.
// - Second word waits in the held register until another transfer starts.
// - Service before a third transfer moves the held word; flag stays.
// - A third transfer start discards the held word; later service clears the flag.
// - Mode fault with interrupt enable raises the interrupt request.
// - Mode fault drops master select, data output and aborts the transfer.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module spi_status_and_data_buffer (
   input  wire logic                    clock_i,
   input  wire logic                    rst_b_i,
   // Avalon-MM slave
   input  wire spi_buf_pkg::avl_req_t   avs_req_i,
   output var  logic [31:0]             avs_readdata_o,
   output var  logic                    avs_waitrequest_o,
   // Shifter side
   input  wire logic                    rx_done_i,
   input  wire spi_buf_pkg::data_word_t rx_shift_word_i,
   input  wire logic                    xfer_start_i,
   input  wire logic                    tx_idle_i,
   input  wire logic                    ss_b_i,
   output var  logic                    tx_load_o,
   output var  spi_buf_pkg::data_word_t tx_word_o,
   output var  logic                    abort_o,
   // Control state to the rest of the module
   output var  logic                    controller_select_o,
   output var  logic                    data_out_en_o,
   output var  logic                    fault_detect_enable_o,
   output var  logic                    transfer_width_o,
   output var  logic                    irq_o
);
   import spi_buf_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic         waitrequest_r;
   logic         waitrequest_nxt;
   logic [31:0]  readdata_r;
   logic [31:0]  readdata_nxt;

   ctrl_one_t    ctrl_one_r;
   ctrl_one_t    ctrl_one_nxt;
   ctrl_two_t    ctrl_two_r;
   ctrl_two_t    ctrl_two_nxt;

   logic         tx_empty_r;
   logic         tx_empty_nxt;
   data_word_t   tx_queue_r;
   data_word_t   tx_queue_nxt;
   data_word_t   tx_word_r;
   data_word_t   tx_word_nxt;
   logic         tx_load_r;
   logic         mode_fault_r;
   logic         mode_fault_nxt;
   logic         rx_arm_r;
   logic         rx_arm_nxt;
   logic         tx_arm_r;
   logic         tx_arm_nxt;
   logic         mf_arm_r;
   logic         mf_arm_nxt;
   logic         abort_r;
   logic         data_out_en_r;
   logic         irq_r;

   data_word_t   rx_data;
   logic         rx_full;
   flag_status_t status_now;
   flag_status_t status_seen;

   ////////////////////////////////////////////////////////////////////////
   // Address decode and access strobes
   wire [IDX_W-1:0] idx       = avs_req_i.address[IDX_LSB +: IDX_W];
   wire             req_act   = avs_req_i.read | avs_req_i.write;
   wire             first_cyc = req_act & waitrequest_r;
   wire             fire      = req_act & ~waitrequest_r;
   wire             fire_rd   = fire & avs_req_i.read;
   wire             fire_wr   = fire & avs_req_i.write & ~avs_req_i.read;
   wire             be0       = avs_req_i.byteenable[0];
   wire             be1       = avs_req_i.byteenable[1];

   wire sel_ctrl_one = (idx == IDX_CTRL_ONE);
   wire sel_ctrl_two = (idx == IDX_CTRL_TWO);
   wire sel_status   = (idx == IDX_FLAG_STATUS);
   wire sel_high     = (idx == IDX_DATA_HIGH);
   wire sel_low      = (idx == IDX_DATA_LOW);
   wire sel_word     = (idx == IDX_DATA_WORD);

   wire wr_ctrl_one  = fire_wr & sel_ctrl_one & be0;
   wire wr_ctrl_two  = fire_wr & sel_ctrl_two & be0;
   wire rd_status    = fire_rd & sel_status;

   // only low or word read services
   wire rd_low       = fire_rd & (sel_low | sel_word);

   wire wr_low_ok    = fire_wr & tx_empty_r & be0 & (sel_low | sel_word);
   wire wr_high_ok   = fire_wr & tx_empty_r & ((sel_high & be0) | (sel_word & be1));
   wire [7:0] wr_high_byte = sel_word ? avs_req_i.writedata[15:8] : avs_req_i.writedata[7:0];
   wire [7:0] wr_low_byte  = avs_req_i.writedata[7:0];

   ////////////////////////////////////////////////////////////////////////
   // Status assembly and read mux
   // unassigned bits zero
   assign status_now.rx_full_flag    = rx_full;
   assign status_now.rsvd6           = 1'b0;
   assign status_now.tx_empty_flag   = tx_empty_r;
   assign status_now.mode_fault_flag = mode_fault_r;
   assign status_now.rsvd3_0         = 4'h0;

   // Value that the pending status read returns to software
   assign status_seen = flag_status_t'(readdata_r[7:0]);

   wire [31:0] rd_mux =
      sel_status   ? {24'h00_0000, status_now} :
      sel_high     ? {24'h00_0000, rx_data.high} :
      sel_low      ? {24'h00_0000, rx_data.low} :
      sel_word     ? {16'h0000, rx_data} :
      sel_ctrl_one ? {24'h00_0000, ctrl_one_r} :
      sel_ctrl_two ? {24'h00_0000, ctrl_two_r} :
                     READ_ZERO;

   // One wait cycle, then the access completes
   always_comb begin
      waitrequest_nxt = 1'b1;
      if (first_cyc) begin
         waitrequest_nxt = 1'b0;
      end
   end

   assign readdata_nxt = (first_cyc && avs_req_i.read) ? rd_mux : readdata_r;

   ////////////////////////////////////////////////////////////////////////
   // Mode fault
   // fault detection as master
   wire fault_event = ~ss_b_i & ctrl_one_r.controller_select & ctrl_two_r.fault_detect_enable;

   // armed read then control one write
   wire mf_clear = wr_ctrl_one & mf_arm_r;

   always_comb begin
      mode_fault_nxt = mode_fault_r;
      mf_arm_nxt     = mf_arm_r;
      if (rd_status && status_seen.mode_fault_flag) begin
         mf_arm_nxt = 1'b1;
      end
      if (mf_clear) begin
         mode_fault_nxt = 1'b0;
         mf_arm_nxt     = 1'b0;
      end
      // A fault in the clearing cycle still wins
      if (fault_event) begin
         mode_fault_nxt = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers
   // status index has no write path
   always_comb begin
      ctrl_one_nxt = ctrl_one_r;
      ctrl_two_nxt = ctrl_two_r;
      if (wr_ctrl_one) begin
         ctrl_one_nxt = ctrl_one_t'(avs_req_i.writedata[7:0] & CTRL_ONE_MASK);
      end
      if (wr_ctrl_two) begin
         ctrl_two_nxt = ctrl_two_t'(avs_req_i.writedata[7:0] & CTRL_TWO_MASK);
      end
      if (fault_event) begin
         ctrl_one_nxt.controller_select = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit path
   // hand queued word to idle shifter
   wire tx_load_fire = ~tx_empty_r & tx_idle_i & ~fault_event;

   always_comb begin
      tx_empty_nxt = tx_empty_r;
      tx_arm_nxt   = tx_arm_r;
      tx_queue_nxt = tx_queue_r;
      tx_word_nxt  = tx_word_r;
      if (rd_status && status_seen.tx_empty_flag) begin
         tx_arm_nxt = 1'b1;
      end
      // high byte kept as last written
      if (wr_high_ok) begin
         tx_queue_nxt.high = wr_high_byte;
      end
      if (wr_low_ok) begin
         tx_queue_nxt.low = wr_low_byte;
      end
      if (wr_low_ok && tx_arm_r) begin
         tx_empty_nxt = 1'b0;
         tx_arm_nxt   = 1'b0;
      end
      if (tx_load_fire) begin
         tx_word_nxt  = tx_queue_r;
         tx_empty_nxt = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive service
   // armed read then low read
   wire rx_service = rd_low & rx_arm_r;

   always_comb begin
      rx_arm_nxt = rx_arm_r;
      if (rd_status && status_seen.rx_full_flag) begin
         rx_arm_nxt = 1'b1;
      end
      if (rx_service) begin
         rx_arm_nxt = 1'b0;
      end
   end

   // flag set by the receive store
   rx_data_hold u_rx_hold (
      .clock_i      (clock_i),
      .rst_b_i      (rst_b_i),
      .rx_done_i    (rx_done_i),
      .rx_word_i    (rx_shift_word_i),
      .xfer_start_i (xfer_start_i),
      .service_i    (rx_service),
      .rx_data_o    (rx_data),
      .rx_full_o    (rx_full)
   );

   ////////////////////////////////////////////////////////////////////////
   // State registers
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         waitrequest_r <= 1'b1;
         readdata_r    <= READ_ZERO;
      end else begin
         waitrequest_r <= waitrequest_nxt;
         readdata_r    <= readdata_nxt;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_one_r   <= ctrl_one_t'(CTRL_ONE_RESET);
         ctrl_two_r   <= ctrl_two_t'(CTRL_TWO_RESET);
         mode_fault_r <= 1'b0;
         mf_arm_r     <= 1'b0;
      end else begin
         ctrl_one_r   <= ctrl_one_nxt;
         ctrl_two_r   <= ctrl_two_nxt;
         mode_fault_r <= mode_fault_nxt;
         mf_arm_r     <= mf_arm_nxt;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_empty_r <= TX_EMPTY_RESET;
         tx_arm_r   <= 1'b0;
         tx_queue_r <= {DATA_RESET, DATA_RESET};
         tx_word_r  <= {DATA_RESET, DATA_RESET};
         tx_load_r  <= 1'b0;
         rx_arm_r   <= 1'b0;
      end else begin
         tx_empty_r <= tx_empty_nxt;
         tx_arm_r   <= tx_arm_nxt;
         tx_queue_r <= tx_queue_nxt;
         tx_word_r  <= tx_word_nxt;
         tx_load_r  <= tx_load_fire;
         rx_arm_r   <= rx_arm_nxt;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         abort_r       <= 1'b0;
         data_out_en_r <= 1'b0;
         irq_r         <= 1'b0;
      end else begin
         abort_r       <= fault_event;
         data_out_en_r <= ctrl_one_nxt.controller_select;
         irq_r         <= mode_fault_nxt & ctrl_one_nxt.irq_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign avs_readdata_o        = readdata_r;
   assign avs_waitrequest_o     = waitrequest_r;
   assign tx_load_o             = tx_load_r;
   assign tx_word_o             = tx_word_r;
   assign abort_o               = abort_r;
   assign controller_select_o   = ctrl_one_r.controller_select;
   assign data_out_en_o         = data_out_en_r;
   assign fault_detect_enable_o = ctrl_two_r.fault_detect_enable;
   assign transfer_width_o      = ctrl_two_r.transfer_width_select;
   assign irq_o                 = irq_r;

endmodule : spi_status_and_data_buffer
`default_nettype wire

// ==== sim/spi_buf_sva.sv ====
// Port-level checker for the SPI status and data buffer
`timescale 1ns/100ps
`default_nettype none
module spi_buf_sva (
   input wire logic                    clock_i,
   input wire logic                    rst_b_i,
   input wire spi_buf_pkg::avl_req_t   avs_req_i,
   input wire logic [31:0]             avs_readdata_o,
   input wire logic                    avs_waitrequest_o,
   input wire logic                    rx_done_i,
   input wire logic                    tx_idle_i,
   input wire logic                    ss_b_i,
   input wire logic                    tx_load_o,
   input wire spi_buf_pkg::data_word_t tx_word_o,
   input wire logic                    abort_o,
   input wire logic                    controller_select_o,
   input wire logic                    data_out_en_o,
   input wire logic                    fault_detect_enable_o
);
   import spi_buf_pkg::*;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   wire logic req_w  = avs_req_i.read | avs_req_i.write;
   wire logic stat_w = avs_req_i.address == {IDX_FLAG_STATUS, 2'b00};

   ////////////////////////////////////////////////////////////
   property p_wait_one; req_w && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
   a_wait_one: assert property (p_wait_one) else $error("request not answered next cycle");
   property p_wait_pulse; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
   a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
   property p_stat_zero;
      avs_req_i.read && !avs_waitrequest_o && stat_w |-> (avs_readdata_o & 32'hFFFF_FF4F) == 32'h0000_0000;
   endproperty
   a_stat_zero: assert property (p_stat_zero) else $error("unused status bits not zero");
   property p_fault; $fell(ss_b_i) && controller_select_o && fault_detect_enable_o |-> ##[1:3] abort_o; endproperty
   a_fault: assert property (p_fault) else $error("no abort after select fault");
   property p_fault_off; abort_o |-> ##[0:1] (!controller_select_o && !data_out_en_o); endproperty
   a_fault_off: assert property (p_fault_off) else $error("master mode kept after fault");
   property p_out_en; data_out_en_o == controller_select_o; endproperty
   a_out_en: assert property (p_out_en) else $error("output enable differs from master select");
   property p_load_idle; tx_load_o |-> $past(tx_idle_i) ##1 !tx_load_o; endproperty
   a_load_idle: assert property (p_load_idle) else $error("load while shifter busy");
   property p_word_hold; !tx_load_o |-> $stable(tx_word_o); endproperty
   a_word_hold: assert property (p_word_hold) else $error("transmit word changed without load");

   c_fault: cover property (abort_o);
   c_load: cover property (tx_load_o);
   c_rx: cover property (rx_done_i);
endmodule : spi_buf_sva

bind spi_status_and_data_buffer spi_buf_sva u_sva (
   .clock_i(clock_i), .rst_b_i(rst_b_i), .avs_req_i(avs_req_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .rx_done_i(rx_done_i), .tx_idle_i(tx_idle_i), .ss_b_i(ss_b_i),
   .tx_load_o(tx_load_o), .tx_word_o(tx_word_o), .abort_o(abort_o), .controller_select_o(controller_select_o),
   .data_out_en_o(data_out_en_o), .fault_detect_enable_o(fault_detect_enable_o));
`default_nettype wire

// ==== sim/spi_peer_model.sv ====
// Shifter and far-side peer stand-in, echoing each word back altered
`timescale 1ns/100ps
`default_nettype none
module spi_peer_model (
   input  wire logic                    clock_i,
   input  wire logic                    rst_b_i,
   input  wire logic                    tx_load_i,
   input  wire spi_buf_pkg::data_word_t tx_word_i,
   input  wire logic                    abort_i,
   input  wire logic [7:0]              dur_i,
   output var  logic                    rx_done_o,
   output var  spi_buf_pkg::data_word_t rx_word_o,
   output var  logic                    xfer_start_o,
   output var  logic                    tx_idle_o
);
   import spi_buf_pkg::*;
   logic [7:0] cnt_r;
   data_word_t shift_r;
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_r <= 8'h00;
         shift_r <= '0;
         rx_done_o <= 1'b0;
         rx_word_o <= '0;
         xfer_start_o <= 1'b0;
         tx_idle_o <= 1'b1;
      end else begin
         rx_done_o <= 1'b0;
         xfer_start_o <= 1'b0;
         // Word only meaningful with done
         rx_word_o <= ~rx_word_o;
         if (abort_i) begin
            tx_idle_o <= 1'b1;
         end else if (tx_load_i) begin
            tx_idle_o <= 1'b0;
            xfer_start_o <= 1'b1;
            cnt_r <= dur_i;
            shift_r <= tx_word_i;
         end else if (!tx_idle_o && cnt_r == 8'h00) begin
            rx_done_o <= 1'b1;
            rx_word_o <= shift_r ^ 16'h5A3C;
            tx_idle_o <= 1'b1;
         end else if (!tx_idle_o) begin
            cnt_r <= cnt_r - 8'h01;
         end
      end
   end
endmodule : spi_peer_model
`default_nettype wire

// ==== sim/spi_status_and_data_buffer_bench.sv ====
// Scenario bench for the SPI status and data buffer
`timescale 1ns/100ps
`default_nettype none
module spi_status_and_data_buffer_bench;
   import spi_buf_pkg::*;
   logic                clock_i = 1'b0;
   logic                rst_b_i = 1'b0;
   avl_req_t            req     = '0;
   logic                ss_b    = 1'b1;
   logic [7:0]          dur     = 8'h0A;
   logic [7:0]          v;
   int                  error_cnt   = 0;
   int                  comparisons = 0;
   wire logic [31:0]    rdata;
   wire logic           wreq, rx_done, xstart, idle, load, abort, csel, oen, fden, xw, irq;
   wire data_word_t     rxw, txw;

   always #4 clock_i = ~clock_i;

   spi_status_and_data_buffer u_dut (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .avs_req_i(req), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .rx_done_i(rx_done), .rx_shift_word_i(rxw), .xfer_start_i(xstart),
      .tx_idle_i(idle), .ss_b_i(ss_b), .tx_load_o(load), .tx_word_o(txw), .abort_o(abort),
      .controller_select_o(csel), .data_out_en_o(oen), .fault_detect_enable_o(fden),
      .transfer_width_o(xw), .irq_o(irq));
   spi_peer_model u_peer (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .tx_load_i(load), .tx_word_i(txw), .abort_i(abort),
      .dur_i(dur), .rx_done_o(rx_done), .rx_word_o(rxw), .xfer_start_o(xstart), .tx_idle_o(idle));

   ////////////////////////////////////////////////////////////
   task automatic results();
      if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One register access, held until waitrequest seen low
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clock_i);
      req <= '{read: !wr, write: wr, address: {idx, 2'b00}, byteenable: 4'h1, writedata: {24'h00_0000, wd}};
      do begin @(posedge clock_i); n++; end while (wreq !== 1'b0 && n < 40);
      v = rdata[7:0];
      if (wreq !== 1'b0) begin error_cnt++; results(); end
      req.read <= 1'b0;
      req.write <= 1'b0;
      // Let the completing edge settle the registers before callers look
      @(posedge clock_i);
   endtask : bus

   // Bounded wait: 0 load, 1 receive, 2 abort
   task automatic wait_for(input int which);
      int n;
      n = 0;
      do begin @(negedge clock_i); n++; end
      while (!(which == 0 ? load === 1'b1 : which == 1 ? rx_done === 1'b1 : abort === 1'b1) && n < 300);
      if (n >= 300) begin error_cnt++; results(); end
   endtask : wait_for

   task automatic send(input logic [15:0] w);
      bus(1'b0, IDX_FLAG_STATUS, 8'h00);
      bus(1'b1, IDX_DATA_HIGH, w[15:8]);
      bus(1'b1, IDX_DATA_LOW, w[7:0]);
   endtask : send

   ////////////////////////////////////////////////////////////
   task automatic t_regs();
      bus(1'b0, IDX_FLAG_STATUS, 8'h00); chk(v, 8'h20);
      bus(1'b0, IDX_DATA_HIGH, 8'h00); chk(v, 8'h00);
      bus(1'b0, IDX_DATA_LOW, 8'h00); chk(v, 8'h00);
      bus(1'b0, IDX_DATA_WORD, 8'h00); chk(v, 8'h00);
      bus(1'b1, IDX_FLAG_STATUS, 8'hFF);
      bus(1'b0, IDX_FLAG_STATUS, 8'h00); chk(v, 8'h20);
      bus(1'b1, 8'h10, 8'hFF);
      bus(1'b0, 8'h10, 8'h00); chk(v, 8'h00);
      bus(1'b1, IDX_CTRL_TWO, 8'h01);
      bus(1'b1, IDX_CTRL_ONE, 8'h08);
      chk({5'h00, csel, oen, xw}, 8'h07);
   endtask : t_regs

   task automatic t_tx_rx();
      bus(1'b0, IDX_FLAG_STATUS, 8'h00);
      bus(1'b1, IDX_DATA_HIGH, 8'hAB);
      bus(1'b1, IDX_DATA_HIGH, 8'hCD);
      bus(1'b0, IDX_FLAG_STATUS, 8'h00); chk(v & 8'h20, 8'h20);
      bus(1'b1, IDX_DATA_LOW, 8'hEF);
      wait_for(0); chk(txw.high, 8'hCD); chk(txw.low, 8'hEF);
      wait_for(1);
      bus(1'b0, IDX_FLAG_STATUS, 8'h00); chk(v & 8'h80, 8'h80);
      bus(1'b0, IDX_DATA_HIGH, 8'h00);
      bus(1'b0, IDX_DATA_HIGH, 8'h00); chk(v, 8'h97);
      bus(1'b0, IDX_FLAG_STATUS, 8'h00); chk(v & 8'h80, 8'h80);
      bus(1'b0, IDX_DATA_LOW, 8'h00); chk(v, 8'hD3);
      bus(1'b0, IDX_FLAG_STATUS, 8'h00); chk(v & 8'h80, 8'h00);
   endtask : t_tx_rx

   task automatic t_busy_hold();
      dur <= 8'h3C;
      send(16'h0102);
      wait_for(0);
      send(16'h1234);
      bus(1'b1, IDX_DATA_HIGH, 8'h99);
      bus(1'b1, IDX_DATA_LOW, 8'h77);
      bus(1'b0, IDX_FLAG_STATUS, 8'h00); chk(v & 8'h20, 8'h00);
      wait_for(0); chk(txw.high, 8'h12); chk(txw.low, 8'h34);
      wait_for(1);
      bus(1'b0, IDX_DATA_HIGH, 8'h00); chk(v, 8'h5B);
      bus(1'b0, IDX_FLAG_STATUS, 8'h00); chk(v & 8'h80, 8'h80);
      bus(1'b0, IDX_DATA_LOW, 8'h00); chk(v, 8'h3E);
      bus(1'b0, IDX_FLAG_STATUS, 8'h00); chk(v & 8'h80, 8'h80);
      bus(1'b0, IDX_DATA_HIGH, 8'h00); chk(v, 8'h48);
      bus(1'b0, IDX_DATA_LOW, 8'h00); chk(v, 8'h08);
   endtask : t_busy_hold

   task automatic t_drop();
      dur <= 8'h0A;
      send(16'h1111);
      wait_for(1);
      send(16'h2222);
      wait_for(1);
      dur <= 8'h3C;
      send(16'h3333);
      wait_for(0);
      bus(1'b0, IDX_FLAG_STATUS, 8'h00);
      bus(1'b0, IDX_DATA_LOW, 8'h00); chk(v, 8'h2D);
      bus(1'b0, IDX_FLAG_STATUS, 8'h00); chk(v & 8'h80, 8'h00);
      wait_for(1);
      bus(1'b0, IDX_FLAG_STATUS, 8'h00); chk(v & 8'h80, 8'h80);
      bus(1'b0, IDX_DATA_LOW, 8'h00); chk(v, 8'h0F);
   endtask : t_drop

   task automatic t_fault();
      bus(1'b1, IDX_CTRL_TWO, 8'h11);
      bus(1'b1, IDX_CTRL_ONE, 8'h88);
      chk({7'h00, fden}, 8'h01);
      ss_b <= 1'b0;
      wait_for(2);
      chk({7'h00, irq}, 8'h01);
      bus(1'b1, IDX_CTRL_ONE, 8'h80);
      ss_b <= 1'b1;
      chk({6'h00, csel, oen}, 8'h00);
      chk({7'h00, irq}, 8'h01);
      bus(1'b0, IDX_FLAG_STATUS, 8'h00); chk(v & 8'h10, 8'h10);
      bus(1'b1, IDX_CTRL_ONE, 8'h80);
      bus(1'b0, IDX_FLAG_STATUS, 8'h00); chk(v & 8'h10, 8'h00);
      chk({7'h00, irq}, 8'h00);
   endtask : t_fault

   initial begin
      repeat (16) @(posedge clock_i);
      rst_b_i <= 1'b1;
      t_regs();
      t_tx_rx();
      t_busy_hold();
      t_drop();
      t_fault();
      results();
   end
endmodule : spi_status_and_data_buffer_bench
`default_nettype wire
